/* File: verilog/osbi_map.vh */
// Overview of operation
// - A channel transmits only while its clear-to-send input is low.
// - Internal strap: channel request-to-send drives its own clear-to-send.
// - External strap: connector clear-to-send line feeds the channel input.
// - Transmit-empty and receive-full flags of all channels are OR-combined.
// - Separate straps gate transmit and receive into the level request; common outputs are ungated.
// - Enabled request is driven on one of eight strap-chosen levels.
// - Address lines A5..A15 match switches; closed means 0, open means 1.
// - Wide strap compares all eleven lines A5..A15, otherwise only A5..A7 decide.
// - Board occupies 32 ports on a 32-port aligned base.
// - Four ports per channel: data, status/sync, mode, command.
// - Transfer and advance acknowledges each strap-delayed 0 to 8 steps.
// - Position N asserts between N-1 and N steps after command start.
// - Position 0 asserts immediately on selection.
// - One step is one constant clock period, nominally 10 MHz.
// - Advance drive strap gates the advance acknowledge driver entirely.
// - Board is slave only, never requests the bus.
// - Channels support sixteen line rates from 50 to 19200 baud.
// - Delay register cleared while idle, shifts ones on constant clock.
// - A4..A2 select channel chip select; A1..A0 select register.
// - Channel read/write line high for write, low for read.
// - Acknowledge drivers enabled only during a command to this board.
`ifndef OSBI_MAP_VH
`define OSBI_MAP_VH
`define OSBI_REG_DATA      2'h0
`define OSBI_REG_STATUS    2'h1
`define OSBI_REG_MODE      2'h2
`define OSBI_REG_COMMAND   2'h3
`define OSBI_DEC_LSB       5
`define OSBI_NARROW_MSB    7
`define OSBI_CHAN_LSB      2
`define OSBI_CHAN_MSB      4
`define OSBI_PORTS         32
`define OSBI_CHANNELS      8
`define OSBI_STEPS         8
`define OSBI_STEP_NS       100
`define OSBI_XACK_DEFAULT  4'h3
`define OSBI_BAUD_RATES    16
`define OSBI_SEL_IDLE      8'h00
`define OSBI_CTS_IDLE      8'hff
`define OSBI_IRQ_IDLE      8'hff
`endif

/* File: verilog/osbi_bus_interface.v */
`timescale 1ns/100ps
`include "osbi_map.vh"
module osbi_bus_interface (
   input  wire        clk_sys,
   input  wire        rst_b,
   input  wire        clk_en,
   input  wire        cclk,
   input  wire [15:0] addr,
   input  wire        io_read_n,
   input  wire        io_write_n,
   input  wire [10:0] addr_switch_closed,
   input  wire        wide_address_strap,
   input  wire [3:0]  xack_delay_strap,
   input  wire [3:0]  aack_delay_strap,
   input  wire        advance_ack_drive_strap,
   input  wire        tx_irq_strap,
   input  wire        rx_irq_strap,
   input  wire [2:0]  irq_level_strap,
   input  wire [7:0]  cts_from_connector_strap,
   input  wire [7:0]  chan_rts_n,
   input  wire [7:0]  conn_cts_n,
   input  wire [7:0]  chan_tx_empty_n,
   input  wire [7:0]  chan_rx_full_n,
   output reg  [7:0]  channel_select,
   output reg  [1:0]  reg_select,
   output reg         chan_rd_wr,
   output reg         data_dir_out,
   output reg  [7:0]  chan_cts_n,
   output reg         common_tx_irq_n,
   output reg         common_rx_irq_n,
   output reg  [7:0]  irq_level_n,
   output reg         xack_n,
   output reg         xack_oe,
   output reg         aack_n,
   output reg         aack_oe,
   output reg         bus_request_n
);

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam DEC_BITS   = 11;
   localparam NARROW_CNT = `OSBI_NARROW_MSB - `OSBI_DEC_LSB + 1;
   localparam CHANNELS   = `OSBI_CHANNELS;
   localparam STEPS      = `OSBI_STEPS;
   // Rate choice sits in each channel's mode port; this side only routes
   // the access there, so the rates need no logic of their own
   localparam BAUD_RATES = `OSBI_BAUD_RATES;

   // ************************************************************
   // Address compare and selection
   // ************************************************************
   wire [DEC_BITS-1:0] line_match;
   wire                low_match;
   wire                high_match;
   wire                board_hit;
   wire                rd_cmd;
   wire                wr_cmd;
   wire                command_on;
   wire                selected;

   genvar ab;
   generate
      for (ab = 0; ab < DEC_BITS; ab = ab + 1) begin : g_addr_cmp
         // A closed switch is a 1 here and asks for a 0 on its line
         assign line_match[ab] = addr[`OSBI_DEC_LSB + ab] ^ addr_switch_closed[ab];
      end
   endgenerate

   assign low_match  = &line_match[NARROW_CNT-1:0];
   assign high_match = &line_match[DEC_BITS-1:NARROW_CNT];
   // Narrow systems leave the upper lines undefined, so they must not vote
   assign board_hit  = low_match & (high_match | ~wide_address_strap);
   assign rd_cmd     = ~io_read_n;
   assign wr_cmd     = ~io_write_n;
   assign command_on = rd_cmd | wr_cmd;
   assign selected   = board_hit & command_on;

   // ************************************************************
   // Channel decode
   // ************************************************************
   wire [2:0]          chan_index;

   assign chan_index = addr[`OSBI_CHAN_MSB:`OSBI_CHAN_LSB];

   // ************************************************************
   // Acknowledge delay chain
   // ************************************************************
   // Constant clock rises step the chain, so one tap is one constant clock
   // period whatever its rate; the command arrives unaligned, which gives
   // the one-step uncertainty window.
   reg                 cclk_last;
   reg  [STEPS-1:0]    delay_taps;
   wire                cclk_rise;
   wire [STEPS:0]      tap_view;
   wire [STEPS-1:0]    next_taps;

   assign cclk_rise = cclk & ~cclk_last;
   // Tap zero is tied high so position 0 answers as soon as the board is hit
   assign tap_view  = {delay_taps, 1'b1};

   genvar tp;
   generate
      for (tp = 0; tp < STEPS; tp = tp + 1) begin : g_taps
         // Idle clears every stage; each constant clock rise moves the ones on
         assign next_taps[tp] = selected &
                                (cclk_rise ? tap_view[tp] : delay_taps[tp]);
      end
   endgenerate

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cclk_last <= 1'b0;
      end else if (clk_en) begin
         cclk_last <= cclk;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         delay_taps <= {STEPS{1'b0}};
      end else if (clk_en) begin
         delay_taps <= next_taps;
      end
   end

   // ************************************************************
   // Acknowledge position select
   // ************************************************************
   reg                 xack_pick;
   reg                 aack_pick;

   always @* begin
      case (xack_delay_strap)
         4'h0: xack_pick = tap_view[0];
         4'h1: xack_pick = tap_view[1];
         4'h2: xack_pick = tap_view[2];
         4'h3: xack_pick = tap_view[3];
         4'h4: xack_pick = tap_view[4];
         4'h5: xack_pick = tap_view[5];
         4'h6: xack_pick = tap_view[6];
         4'h7: xack_pick = tap_view[7];
         4'h8: xack_pick = tap_view[8];
         // Positions past the last tap behave as an unfitted plug
         default: xack_pick = 1'b0;
      endcase
   end

   always @* begin
      case (aack_delay_strap)
         4'h0: aack_pick = tap_view[0];
         4'h1: aack_pick = tap_view[1];
         4'h2: aack_pick = tap_view[2];
         4'h3: aack_pick = tap_view[3];
         4'h4: aack_pick = tap_view[4];
         4'h5: aack_pick = tap_view[5];
         4'h6: aack_pick = tap_view[6];
         4'h7: aack_pick = tap_view[7];
         4'h8: aack_pick = tap_view[8];
         // Positions past the last tap behave as an unfitted plug
         default: aack_pick = 1'b0;
      endcase
   end

   // ************************************************************
   // Clear-to-send steering per channel
   // ************************************************************
   wire [CHANNELS-1:0] next_cts_n;

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_cts
         // Internal strap loops request-to-send back so silent devices still send
         assign next_cts_n[ch] = cts_from_connector_strap[ch] ? conn_cts_n[ch]
                                                              : chan_rts_n[ch];
      end
   endgenerate

   // ************************************************************
   // Interrupt merge
   // ************************************************************
   wire                tx_any;
   wire                rx_any;
   wire                tx_req;
   wire                rx_req;
   wire                irq_any;
   wire [7:0]          level_onehot;

   assign tx_any       = ~&chan_tx_empty_n;
   assign rx_any       = ~&chan_rx_full_n;
   assign tx_req       = tx_any & tx_irq_strap;
   assign rx_req       = rx_any & rx_irq_strap;
   assign irq_any      = tx_req | rx_req;
   assign level_onehot = 8'h01 << irq_level_strap;

   // ************************************************************
   // Next output values
   // ************************************************************
   // Every output is registered so the bus and channels see clean levels
   reg [7:0]           next_channel_select;
   reg [1:0]           next_reg_select;
   reg                 next_chan_rd_wr;
   reg                 next_data_dir_out;
   reg [7:0]           next_irq_level_n;
   reg                 next_xack_n;
   reg                 next_xack_oe;
   reg                 next_aack_n;
   reg                 next_aack_oe;

   always @* begin
      next_channel_select = selected ? (8'h01 << chan_index) : `OSBI_SEL_IDLE;
      next_reg_select     = addr[1:0];
      next_chan_rd_wr     = wr_cmd;
      next_data_dir_out   = selected & rd_cmd;
      next_irq_level_n    = irq_any ? ~level_onehot : `OSBI_IRQ_IDLE;
      next_xack_n         = ~(selected & xack_pick);
      next_xack_oe        = selected;
      next_aack_n         = ~(selected & aack_pick);
      next_aack_oe        = selected & advance_ack_drive_strap;
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         channel_select <= `OSBI_SEL_IDLE;
      end else if (clk_en) begin
         channel_select <= next_channel_select;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         reg_select <= 2'h0;
      end else if (clk_en) begin
         reg_select <= next_reg_select;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         chan_rd_wr <= 1'b0;
      end else if (clk_en) begin
         chan_rd_wr <= next_chan_rd_wr;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         data_dir_out <= 1'b0;
      end else if (clk_en) begin
         data_dir_out <= next_data_dir_out;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         chan_cts_n <= `OSBI_CTS_IDLE;
      end else if (clk_en) begin
         chan_cts_n <= next_cts_n;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         common_tx_irq_n <= 1'b1;
      end else if (clk_en) begin
         common_tx_irq_n <= ~tx_any;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         common_rx_irq_n <= 1'b1;
      end else if (clk_en) begin
         common_rx_irq_n <= ~rx_any;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_level_n <= `OSBI_IRQ_IDLE;
      end else if (clk_en) begin
         irq_level_n <= next_irq_level_n;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         xack_n <= 1'b1;
      end else if (clk_en) begin
         xack_n <= next_xack_n;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         xack_oe <= 1'b0;
      end else if (clk_en) begin
         xack_oe <= next_xack_oe;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         aack_n <= 1'b1;
      end else if (clk_en) begin
         aack_n <= next_aack_n;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         aack_oe <= 1'b0;
      end else if (clk_en) begin
         aack_oe <= next_aack_oe;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         bus_request_n <= 1'b1;
      end else if (clk_en) begin
         bus_request_n <= 1'b1;
      end
   end

endmodule

/* File: testbench/osbi_bus_interface_chk.sv */
`timescale 1ns/100ps
module osbi_bus_interface_chk (
   input logic        clk_sys, rst_b, io_read_n, io_write_n, wide_address_strap,
   input logic        advance_ack_drive_strap, chan_rd_wr, data_dir_out, common_rx_irq_n,
   input logic        xack_n, xack_oe, aack_oe, bus_request_n,
   input logic [15:0] addr,
   input logic [10:0] addr_switch_closed,
   input logic [3:0]  xack_delay_strap,
   input logic [1:0]  reg_select,
   input logic [7:0]  chan_rts_n, conn_cts_n, cts_from_connector_strap, chan_rx_full_n,
   input logic [7:0]  channel_select, chan_cts_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Upper eight compares drop out in narrow mode
   wire [10:0] miss = (addr[15:5] ^ ~addr_switch_closed) & {{8{wide_address_strap}}, 3'h7};
   wire        sel  = (miss == 11'h0) && !(io_read_n && io_write_n);
   sel_decode_a: assert property (sel |=> xack_oe && reg_select == $past(addr[1:0])
      && channel_select == 8'h1 << $past(addr[4:2])) else $error("bad select");
   idle_release_a: assert property (!sel |=> !xack_oe && !aack_oe && xack_n
      && channel_select == 8'h0) else $error("drives while idle");
   rw_dir_a: assert property (sel |=> chan_rd_wr == !$past(io_write_n)
      && data_dir_out == !$past(io_read_n)) else $error("bad direction");
   aack_gate_a: assert property (!advance_ack_drive_strap |=> !aack_oe) else $error("aack");
   pos_zero_a: assert property (sel && xack_delay_strap == 4'h0 |=> !xack_n) else $error("p0");
   no_early_a: assert property ($rose(xack_oe) && xack_delay_strap > 4'h1 |-> xack_n [*8])
      else $error("early ack");
   cts_route_a: assert property (1 |=> chan_cts_n == $past(cts_from_connector_strap & conn_cts_n
      | ~cts_from_connector_strap & chan_rts_n)) else $error("cts route");
   rx_merge_a: assert property (1 |=> common_rx_irq_n == &$past(chan_rx_full_n)) else $error("rx");
   slave_only_a: assert property (bus_request_n) else $error("bus request");
   cover property (sel && !io_write_n);
   cover property (sel && xack_delay_strap == 4'h8);
   cover property (sel && !advance_ack_drive_strap);
endmodule
bind osbi_bus_interface osbi_bus_interface_chk chk (.*);

/* File: testbench/osbi_master_model.sv */
`timescale 1ns/100ps
module osbi_master_model (
   input  logic        clk_sys, xack_n, xack_oe,
   output logic        cclk, io_read_n, io_write_n,
   output logic [15:0] addr
);
   int ph = 0;
   initial begin cclk = 0; addr = 16'h0; io_read_n = 1; io_write_n = 1; end
   // Constant clock runs free, near 10 MHz
   always @(negedge clk_sys) begin ph = (ph == 5) ? 0 : ph + 1; if (ph == 0) cclk = ~cclk; end
   task automatic cyc(input logic [15:0] a, input logic wr, output int n);
      @(negedge clk_sys); addr = a; io_write_n = !wr; io_read_n = wr; n = 0;
      while (!(xack_oe === 1'b1 && xack_n === 1'b0) && n < 400) begin
         @(negedge clk_sys); n++; end
      io_read_n = 1; io_write_n = 1; addr = ~a; repeat (2) @(negedge clk_sys);
   endtask
endmodule

/* File: testbench/osbi_bus_interface_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module osbi_bus_interface_tb_top;
   logic        clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cclk, io_read_n, io_write_n;
   logic        wide_address_strap, advance_ack_drive_strap, tx_irq_strap, rx_irq_strap;
   logic        chan_rd_wr, data_dir_out, common_tx_irq_n, common_rx_irq_n, lrw;
   logic        xack_n, xack_oe, aack_n, aack_oe, bus_request_n;
   logic [15:0] addr;
   logic [10:0] addr_switch_closed;
   logic [3:0]  xack_delay_strap, aack_delay_strap;
   logic [2:0]  irq_level_strap;
   logic [1:0]  reg_select;
   logic [7:0]  cts_from_connector_strap, chan_rts_n, conn_cts_n, chan_tx_empty_n, chan_rx_full_n;
   logic [7:0]  channel_select, chan_cts_n, irq_level_n, lcs;
   logic [1:0]  lak;
   int          num_errors = 0, compares = 0, cyc_cnt = 0, n;
   osbi_bus_interface dut (.*);
   osbi_master_model mst (.*);
   initial forever #4 clk_sys = ~clk_sys;
   always @(negedge clk_sys) if (xack_oe) begin
      lcs = channel_select; lrw = chan_rd_wr; lak = {aack_oe, aack_n}; end
   always @(posedge clk_sys) begin cyc_cnt++; if (cyc_cnt == 10000) begin num_errors++; end_sim; end end
   task end_sim;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task t_ack;
      for (int k = 0; k <= 8; k++) begin
         xack_delay_strap = k[3:0]; mst.cyc({~addr_switch_closed, 5'h0}, 1'b0, n);
         `CHK(n <= 12 * k + 5 && n + 14 > 12 * k, 1'b1)
         if (k >= 3) `CHK(lak, 2'b10)
      end
      $display("ack test done");
   endtask
   task t_addr;
      for (int c = 0; c < 8; c++) begin
         mst.cyc({~addr_switch_closed, c[2:0], c[1:0]}, c[0], n);
         `CHK({lcs, lrw}, {8'h1 << c, c[0]})
      end
      mst.cyc({~addr_switch_closed ^ 11'h008, 5'h0}, 1'b0, n);
      `CHK(n, 400)
      wide_address_strap = 1'b0; mst.cyc({~addr_switch_closed ^ 11'h008, 5'h0}, 1'b0, n);
      `CHK(n < 400, 1'b1)
      mst.cyc({~addr_switch_closed ^ 11'h001, 5'h0}, 1'b1, n);
      `CHK(n, 400)
      $display("address test done");
   endtask
   task t_side;
      cts_from_connector_strap = 8'h0f; chan_rts_n = 8'h33; conn_cts_n = 8'h55;
      chan_tx_empty_n = 8'hef; tx_irq_strap = 1; irq_level_strap = 3'h5;
      repeat (3) @(negedge clk_sys);
      `CHK(chan_cts_n, 8'h35)
      `CHK({common_tx_irq_n, irq_level_n, bus_request_n}, {1'b0, 8'hdf, 1'b1})
      tx_irq_strap = 0; rx_irq_strap = 1; chan_rx_full_n = 8'h7f; irq_level_strap = 3'h0;
      repeat (3) @(negedge clk_sys);
      `CHK({common_rx_irq_n, irq_level_n}, {1'b0, 8'hfe})
      rx_irq_strap = 0; repeat (3) @(negedge clk_sys);
      `CHK(irq_level_n, 8'hff)
      $display("side test done");
   endtask
   initial begin
      addr_switch_closed = 11'h5a5; wide_address_strap = 1; advance_ack_drive_strap = 1;
      xack_delay_strap = 4'h3; aack_delay_strap = 4'h2; irq_level_strap = 3'h0;
      tx_irq_strap = 0; rx_irq_strap = 0; cts_from_connector_strap = 8'h0; chan_rts_n = 8'hff;
      conn_cts_n = 8'hff; chan_tx_empty_n = 8'hff; chan_rx_full_n = 8'hff;
      repeat (20) @(negedge clk_sys);
      rst_b = 1'b1;
      t_ack; advance_ack_drive_strap = 0; t_addr; t_side; end_sim;
   end
endmodule
